// >>> rtl/xps_route_power_regs.sv
// Management-bus slave and route/power registers of a 4x4 crosspoint switch.
// Assumes clk is far faster than the bus clock; all pins are asynchronous to clk.
//
// Contract
// - Each transfer is eight bits, MSB first, plus acknowledge.
// - Acknowledge is low; not-acknowledge is left high.
// - Write is address, index, data; data stored.
// - Further write bytes advance the index each time.
// - Read: index write, repeated start, address read, data.
// - Registers at index 0, 3, 4; status read-only.
// - Routing holds four 2-bit selectors, reset zero.
// - Selector value picks the input of that number.
// - Unused inputs are powered down automatically unless monitor is set; outputs follow their enable bits while powered up.
// - Control bits 3:0 enable outputs, reset ones.
// - Monitor bit enables all input receivers and monitors.
// - Power-up when soft bit or pin high.
// - Power-down keeps bus slave; monitor still works.
// - Output enabled if powered up and its enable set.
// - Input enabled if powered up and needed, or monitor set.
// - Slave responds only while mode-select pin high.
// - Address is 101 then four strap bits.
// - Status bit low means open input; 7:4 reserved.
`default_nettype none

module xps_route_power_regs
  import xps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busClockPin,
  input wire logic busDataIn,
  output logic busDataOut,
  output logic busDataOe,
  input wire logic busModeSelect,
  input wire logic [3:0] busIdStrap,
  input wire logic powerDownPin,
  input wire logic [3:0] inputSignalValid,
  output logic [7:0] outputSelect,
  output logic [3:0] outputPortEnable,
  output logic [3:0] inputPortEnable,
  output logic monitorEnable,
  output logic powerUpMode
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers for the static pins
  // ----------------------------------------------------------------------------
  localparam int unsigned STATIC_PINS = 10;

  logic [STATIC_PINS-1:0] staticMeta_reg;
  logic [STATIC_PINS-1:0] staticSync_reg;
  logic modeSync;
  logic powerPinSync;
  logic [3:0] strapSync;
  logic [3:0] validSync;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      staticMeta_reg <= '0;
      staticSync_reg <= '0;
    end
    else
    begin
      staticMeta_reg <= {inputSignalValid, busIdStrap, powerDownPin, busModeSelect};
      staticSync_reg <= staticMeta_reg;
    end
  end

  assign modeSync = staticSync_reg[0];
  assign powerPinSync = staticSync_reg[1];
  assign strapSync = staticSync_reg[5:2];
  assign validSync = staticSync_reg[9:6];

  // ----------------------------------------------------------------------------
  // Bus clock and data front end
  // ----------------------------------------------------------------------------
  xps_bus_if busEvents();

  xps_smb_front frontEnd
  (
    .clk(clk),
    .rst_b(rst_b),
    .busClockPin(busClockPin),
    .busDataPin(busDataIn),
    .events(busEvents)
  );

  // ----------------------------------------------------------------------------
  // Registers and helpers
  // ----------------------------------------------------------------------------
  logic [7:0] routing_reg;
  logic [3:0] outputBits_reg;
  logic [1:0] spareBits_reg;
  logic monitorBit_reg;
  logic softOnBit_reg;

  xps_state_e state_reg;
  xps_byte_e byteKind_reg;
  logic [3:0] bitCount_reg;
  logic [7:0] shift_reg;
  logic [7:0] txShift_reg;
  logic [7:0] index_reg;
  logic readDir_reg;
  logic hostAcked_reg;
  logic dataOe_reg;
  logic dataOut_reg;

  logic [6:0] ownAddress;
  logic [7:0] controlView;
  logic [7:0] statusView;
  logic [7:0] readNow;

  assign ownAddress = {ADDR_FIXED_BITS, strapSync};
  assign controlView = {softOnBit_reg, monitorBit_reg, spareBits_reg, outputBits_reg};
  assign statusView = {STATUS_RESERVED_VALUE, validSync};

  // Read mux; unmapped indexes read as zero.
  function automatic logic [7:0] readValue(input logic [7:0] idx, input logic [7:0] route,
                                           input logic [7:0] ctrl, input logic [7:0] stat);
    logic [7:0] value;
    value = 8'h00;
    unique case (idx)
      IDX_SWITCH_ROUTING: value = route;
      IDX_POWER_CONTROL: value = ctrl;
      IDX_SIGNAL_LOSS: value = stat;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  assign readNow = readValue(index_reg, routing_reg, controlView, statusView);

  // True when output n routes input i and is allowed to run.
  function automatic logic routesInput(input logic [7:0] route, input logic [3:0] outBits,
                                       input int unsigned n, input int unsigned i);
    logic hit;
    hit = (route[n*SELECT_BITS +: SELECT_BITS] == i[SELECT_BITS-1:0]) && outBits[n];
    return hit;
  endfunction

  // ----------------------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------------------
  logic writeCommit;
  assign writeCommit = (state_reg == ST_ACK) && busEvents.clockFall && (byteKind_reg == BY_DATA);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      byteKind_reg <= BY_ADDRESS;
      bitCount_reg <= 4'h0;
      shift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      index_reg <= 8'h00;
      readDir_reg <= 1'b0;
      hostAcked_reg <= 1'b0;
      dataOe_reg <= 1'b0;
    end
    else if (!modeSync)
    begin
      state_reg <= ST_IDLE;
      dataOe_reg <= 1'b0;
    end
    else if (busEvents.stopSeen)
    begin
      state_reg <= ST_IDLE;
      dataOe_reg <= 1'b0;
    end
    else if (busEvents.startSeen)
    begin
      // A repeated start restarts address decode but keeps the index.
      state_reg <= ST_RECEIVE;
      byteKind_reg <= BY_ADDRESS;
      bitCount_reg <= 4'h0;
      dataOe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          dataOe_reg <= 1'b0;
        end
        ST_RECEIVE:
        begin
          if (busEvents.clockRise && bitCount_reg != FULL_BYTE_COUNT)
          begin
            shift_reg <= {shift_reg[6:0], busEvents.dataLevel};
            bitCount_reg <= bitCount_reg + 4'h1;
          end
          else if (busEvents.clockFall && bitCount_reg == FULL_BYTE_COUNT)
          begin
            if (byteKind_reg == BY_ADDRESS && shift_reg[7:1] != ownAddress)
            begin
              state_reg <= ST_IDLE;
            end
            else
            begin
              state_reg <= ST_ACK;
              dataOe_reg <= 1'b1;
              if (byteKind_reg == BY_ADDRESS)
              begin
                readDir_reg <= shift_reg[0];
              end
              else if (byteKind_reg == BY_INDEX)
              begin
                index_reg <= shift_reg;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (busEvents.clockFall)
          begin
            bitCount_reg <= 4'h0;
            if (byteKind_reg == BY_ADDRESS && readDir_reg)
            begin
              state_reg <= ST_SEND;
              txShift_reg <= readNow;
              dataOe_reg <= ~readNow[7];
            end
            else
            begin
              state_reg <= ST_RECEIVE;
              dataOe_reg <= 1'b0;
              if (byteKind_reg == BY_ADDRESS)
              begin
                byteKind_reg <= BY_INDEX;
              end
              else if (byteKind_reg == BY_INDEX)
              begin
                byteKind_reg <= BY_DATA;
              end
              else
              begin
                index_reg <= index_reg + 8'h01;
              end
            end
          end
        end
        ST_SEND:
        begin
          if (busEvents.clockRise)
          begin
            bitCount_reg <= bitCount_reg + 4'h1;
          end
          else if (busEvents.clockFall)
          begin
            if (bitCount_reg == FULL_BYTE_COUNT)
            begin
              state_reg <= ST_HOST_ACK;
              dataOe_reg <= 1'b0;
            end
            else
            begin
              txShift_reg <= {txShift_reg[6:0], 1'b0};
              dataOe_reg <= ~txShift_reg[6];
            end
          end
        end
        ST_HOST_ACK:
        begin
          if (busEvents.clockRise)
          begin
            hostAcked_reg <= ~busEvents.dataLevel;
            if (busEvents.dataLevel)
            begin
              state_reg <= ST_IDLE;
            end
            else
            begin
              index_reg <= index_reg + 8'h01;
            end
          end
          else if (busEvents.clockFall && hostAcked_reg)
          begin
            state_reg <= ST_SEND;
            bitCount_reg <= 4'h0;
            txShift_reg <= readNow;
            dataOe_reg <= ~readNow[7];
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      routing_reg <= ROUTING_RESET;
      outputBits_reg <= OUTPUT_ENABLE_RESET;
      spareBits_reg <= SPARE_CTRL_RESET;
      monitorBit_reg <= MONITOR_ENABLE_RESET;
      softOnBit_reg <= SOFT_POWER_ON_RESET;
    end
    else if (writeCommit)
    begin
      // Stored at the clock fall that ends the data acknowledge.
      if (index_reg == IDX_SWITCH_ROUTING)
      begin
        routing_reg <= shift_reg;
      end
      else if (index_reg == IDX_POWER_CONTROL)
      begin
        outputBits_reg <= shift_reg[PORT_COUNT-1:0];
        spareBits_reg <= shift_reg[CTRL_SPARE_LSB +: 2];
        monitorBit_reg <= shift_reg[CTRL_MONITOR_BIT];
        softOnBit_reg <= shift_reg[CTRL_SOFT_ON_BIT];
      end
      // Any other index, status included, is acknowledged and dropped.
    end
  end

  // ----------------------------------------------------------------------------
  // Datapath enables
  // ----------------------------------------------------------------------------
  logic powerUpNext;
  logic [3:0] outputEnableNext;
  logic [3:0] inputEnableNext;

  assign powerUpNext = softOnBit_reg | powerPinSync;

  genvar g;
  generate
    for (g = 0; g < PORT_COUNT; g++)
    begin : gen_port
      logic needed;
      assign needed = routesInput(routing_reg, outputBits_reg, 0, g)
                    | routesInput(routing_reg, outputBits_reg, 1, g)
                    | routesInput(routing_reg, outputBits_reg, 2, g)
                    | routesInput(routing_reg, outputBits_reg, 3, g);
      assign outputEnableNext[g] = powerUpNext & outputBits_reg[g];
      assign inputEnableNext[g] = monitorBit_reg | (powerUpNext & needed);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      outputSelect <= ROUTING_RESET;
      outputPortEnable <= 4'h0;
      inputPortEnable <= 4'h0;
      monitorEnable <= MONITOR_ENABLE_RESET;
      powerUpMode <= 1'b0;
    end
    else
    begin
      outputSelect <= routing_reg;
      outputPortEnable <= outputEnableNext;
      inputPortEnable <= inputEnableNext;
      monitorEnable <= monitorBit_reg;
      powerUpMode <= powerUpNext;
    end
  end

  // ----------------------------------------------------------------------------
  // Open-drain data pin
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataOut_reg <= 1'b0;
    end
    else
    begin
      dataOut_reg <= 1'b0;
    end
  end

  assign busDataOut = dataOut_reg;
  assign busDataOe = dataOe_reg;

endmodule

`default_nettype wire

// >>> rtl/xps_pkg.sv
// Constants shared by the crosspoint management-bus register logic.
// Assumes a single 100 MHz system clock and a management bus far slower than it.
`default_nettype none

package xps_pkg;

  // ----------------------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------------------
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT_COUNT = 4'h7;
  localparam logic [3:0] FULL_BYTE_COUNT = 4'h8;
  localparam logic [2:0] ADDR_FIXED_BITS = 3'h5;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------------------
  localparam logic [7:0] IDX_SWITCH_ROUTING = 8'h00;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h03;
  localparam logic [7:0] IDX_SIGNAL_LOSS = 8'h04;

  // ----------------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ROUTING_RESET = 8'h00;
  localparam logic [3:0] OUTPUT_ENABLE_RESET = 4'hf;
  localparam logic [1:0] SPARE_CTRL_RESET = 2'h0;
  localparam logic MONITOR_ENABLE_RESET = 1'b0;
  localparam logic SOFT_POWER_ON_RESET = 1'b0;
  localparam int unsigned CTRL_SPARE_LSB = 4;
  localparam int unsigned CTRL_MONITOR_BIT = 6;
  localparam int unsigned CTRL_SOFT_ON_BIT = 7;
  localparam logic [3:0] STATUS_RESERVED_VALUE = 4'h0;
  localparam int unsigned PORT_COUNT = 4;
  localparam int unsigned SELECT_BITS = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECEIVE,
    ST_ACK,
    ST_SEND,
    ST_HOST_ACK
  } xps_state_e;

  typedef enum logic [1:0] {
    BY_ADDRESS,
    BY_INDEX,
    BY_DATA
  } xps_byte_e;

endpackage

`default_nettype wire

// >>> rtl/xps_bus_if.sv
// Bus events passed from the pin front end to the byte engine.
// Assumes both ends run on the same system clock.
`default_nettype none

interface xps_bus_if;
  logic clockRise;
  logic clockFall;
  logic dataLevel;
  logic startSeen;
  logic stopSeen;

  modport front
  (
    output clockRise,
    output clockFall,
    output dataLevel,
    output startSeen,
    output stopSeen
  );

  modport engine
  (
    input clockRise,
    input clockFall,
    input dataLevel,
    input startSeen,
    input stopSeen
  );
endinterface

`default_nettype wire

// >>> rtl/xps_smb_front.sv
// Pin front end: synchronises bus clock and data and finds edges, start and stop.
// Assumes the pins are asynchronous to clk and change far slower than it.
`default_nettype none

module xps_smb_front
  import xps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busClockPin,
  input wire logic busDataPin,
  xps_bus_if.front events
);

  // ----------------------------------------------------------------------------
  // Two-flop synchronisers and one history stage
  // ----------------------------------------------------------------------------
  logic [SYNC_STAGES-1:0] clockSync_reg;
  logic [SYNC_STAGES-1:0] dataSync_reg;
  logic clockPrev_reg;
  logic dataPrev_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clockSync_reg <= '1;
      dataSync_reg <= '1;
      clockPrev_reg <= 1'b1;
      dataPrev_reg <= 1'b1;
    end
    else
    begin
      clockSync_reg <= {clockSync_reg[0], busClockPin};
      dataSync_reg <= {dataSync_reg[0], busDataPin};
      clockPrev_reg <= clockSync_reg[1];
      dataPrev_reg <= dataSync_reg[1];
    end
  end

  // ----------------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------------
  // Data moving while the clock stays high marks start or stop.
  always_comb
  begin
    events.clockRise = clockSync_reg[1] & ~clockPrev_reg;
    events.clockFall = ~clockSync_reg[1] & clockPrev_reg;
    events.dataLevel = dataSync_reg[1];
    events.startSeen = clockSync_reg[1] & clockPrev_reg & dataPrev_reg & ~dataSync_reg[1];
    events.stopSeen = clockSync_reg[1] & clockPrev_reg & ~dataPrev_reg & dataSync_reg[1];
  end

endmodule

`default_nettype wire

// >>> tb/xps_route_power_regs_assertions.sv
// Checker for the crosspoint route and power register block.
// Assumes one clock domain and sees only the top module's ports.
`default_nettype none

module xps_regs_checker
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busClockPin,
  input wire logic busDataOut,
  input wire logic busDataOe,
  input wire logic busModeSelect,
  input wire logic powerDownPin,
  input wire logic [7:0] outputSelect,
  input wire logic [3:0] outputPortEnable,
  input wire logic [3:0] inputPortEnable,
  input wire logic monitorEnable,
  input wire logic powerUpMode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] prevOuts;
  logic [1:0] quietCnt;
  logic [3:0] neededIn;
  logic settled;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Inputs routed to some enabled output.
  always_comb
  begin
    neededIn = 4'h0;
    for (int n = 0; n < 4; n++)
    begin
      if (outputPortEnable[n])
      begin
        neededIn[outputSelect[2*n+:2]] = 1'b1;
      end
    end
  end

  // Relations are judged only once the outputs have stood still for three cycles.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prevOuts <= '0;
      quietCnt <= 2'h0;
    end
    else
    begin
      prevOuts <= {outputSelect, outputPortEnable, inputPortEnable, monitorEnable, powerUpMode};
      if (prevOuts != {outputSelect, outputPortEnable, inputPortEnable, monitorEnable, powerUpMode})
      begin
        quietCnt <= 2'h0;
      end
      else if (quietCnt != 2'h3)
      begin
        quietCnt <= quietCnt + 2'h1;
      end
    end
  end
  assign settled = (quietCnt == 2'h3);

  sequence s_ack_rise;
    $rose(busClockPin) && busDataOe;
  endsequence
  sequence s_bus_idle;
    busClockPin [*8];
  endsequence
  sequence s_mode_off;
    !busModeSelect [*5];
  endsequence

  property p_out_needs_power;
    settled && !powerUpMode |-> outputPortEnable == 4'h0;
  endproperty
  property p_in_needed;
    settled && powerUpMode |-> (inputPortEnable & neededIn) == neededIn;
  endproperty
  property p_in_unused_off;
    settled && !monitorEnable |-> (inputPortEnable & ~neededIn) == 4'h0;
  endproperty
  property p_monitor_all;
    settled && monitorEnable |-> inputPortEnable == 4'hF;
  endproperty
  property p_pin_powers_up;
    $rose(powerDownPin) |-> ##[1:8] powerUpMode;
  endproperty
  property p_drive_low_only;
    busDataOe |-> !busDataOut;
  endproperty
  property p_ack_held;
    s_ack_rise |-> busDataOe [*3];
  endproperty
  property p_idle_released;
    s_bus_idle |-> !busDataOe;
  endproperty
  property p_mode_off_silent;
    s_mode_off |-> !busDataOe;
  endproperty

  a_out_needs_power: assert property (p_out_needs_power)
    else $error("output enabled outside power-up mode");
  a_in_needed: assert property (p_in_needed)
    else $error("routed input not enabled");
  a_in_unused_off: assert property (p_in_unused_off)
    else $error("unused input left enabled");
  a_monitor_all: assert property (p_monitor_all)
    else $error("monitor set but inputs not all enabled");
  a_pin_powers_up: assert property (p_pin_powers_up)
    else $error("pin high did not give power-up mode");
  a_drive_low_only: assert property (p_drive_low_only)
    else $error("data driven to a high level");
  a_ack_held: assert property (p_ack_held)
    else $error("data released while bus clock high");
  a_idle_released: assert property (p_idle_released)
    else $error("data held on an idle bus");
  a_mode_off_silent: assert property (p_mode_off_silent)
    else $error("slave drove data with mode select low");
endmodule

bind xps_route_power_regs xps_regs_checker i_xps_regs_checker
(
  .clk(clk),
  .rst_b(rst_b),
  .busClockPin(busClockPin),
  .busDataOut(busDataOut),
  .busDataOe(busDataOe),
  .busModeSelect(busModeSelect),
  .powerDownPin(powerDownPin),
  .outputSelect(outputSelect),
  .outputPortEnable(outputPortEnable),
  .inputPortEnable(inputPortEnable),
  .monitorEnable(monitorEnable),
  .powerUpMode(powerUpMode)
);

`default_nettype wire

// >>> tb/xps_smb_host.sv
// Behavioural management-bus host driving bus clock and data.
// Assumes busDataIn is the resolved line with a pull-up; clock stands high between frames.
`default_nettype none

module xps_smb_host
(
  input wire logic clk,
  output logic busClockPin,
  output logic hostData,
  input wire logic busDataIn
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    busClockPin = 1'b1;
    hostData = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // A long low phase waits for the slave before bits it may drive.
  task automatic bitCycle(input logic b, input int pre, output logic s);
    tick(pre);
    hostData <= b;
    tick(2);
    busClockPin <= 1'b1;
    tick(4);
    s = busDataIn;
    busClockPin <= 1'b0;
  endtask

  task automatic startCond();
    tick(6);
    hostData <= 1'b1;
    tick(2);
    busClockPin <= 1'b1;
    tick(4);
    hostData <= 1'b0;
    tick(4);
    busClockPin <= 1'b0;
  endtask

  task automatic stopCond();
    tick(6);
    hostData <= 1'b0;
    tick(2);
    busClockPin <= 1'b1;
    tick(4);
    hostData <= 1'b1;
    tick(8);
  endtask

  task automatic sendByte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitCycle(v[i], (i == 7) ? 6 : 2, s);
    end
    bitCycle(1'b1, 6, s);
    ack = !s;
  endtask

  task automatic recvByte(input logic hostAck, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitCycle(1'b1, 6, s);
      v[i] = s;
    end
    bitCycle(!hostAck, 6, s);
  endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the crosspoint route and power register block.
// Assumes the host model of xps_smb_host and a pull-up on the bus data line.
`default_nettype none

module tb
  import xps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TIMEOUT_CYCLES = 60000;
  logic clk, rst_b, busClockPin, hostData, busDataIn, busDataOut, busDataOe;
  logic busModeSelect, powerDownPin, monitorEnable, powerUpMode;
  logic [3:0] busIdStrap, inputSignalValid, outputPortEnable, inputPortEnable;
  logic [7:0] outputSelect, curRoute, curCtrl;
  logic [6:0] devAddr;
  int numErrors, checksDone;
  int cycles = 0;

  assign busDataIn = hostData & ~busDataOe;

  xps_route_power_regs i_xps_route_power_regs
  (
    .clk(clk),
    .rst_b(rst_b),
    .busClockPin(busClockPin),
    .busDataIn(busDataIn),
    .busDataOut(busDataOut),
    .busDataOe(busDataOe),
    .busModeSelect(busModeSelect),
    .busIdStrap(busIdStrap),
    .powerDownPin(powerDownPin),
    .inputSignalValid(inputSignalValid),
    .outputSelect(outputSelect),
    .outputPortEnable(outputPortEnable),
    .inputPortEnable(inputPortEnable),
    .monitorEnable(monitorEnable),
    .powerUpMode(powerUpMode)
  );

  xps_smb_host i_xps_smb_host
  (
    .clk(clk),
    .busClockPin(busClockPin),
    .hostData(hostData),
    .busDataIn(busDataIn)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES)
    begin
      numErrors++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [19:0] got, input logic [19:0] want);
    checksDone++;
    if (got !== want)
    begin
      numErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic regWrite(input logic [7:0] idx, input logic [15:0] data, input int n, input logic expAck);
    logic ack;
    i_xps_smb_host.startCond();
    i_xps_smb_host.sendByte({devAddr, 1'b0}, ack);
    check(20'(ack), 20'(expAck));
    if (ack)
    begin
      i_xps_smb_host.sendByte(idx, ack);
      check(20'(ack), 20'h1);
      for (int i = 0; i < n; i++)
      begin
        i_xps_smb_host.sendByte(data[15-8*i-:8], ack);
        check(20'(ack), 20'h1);
      end
    end
    i_xps_smb_host.stopCond();
  endtask

  task automatic regRead(input logic [7:0] idx, input int n, output logic [15:0] v);
    logic ack;
    logic [7:0] b;
    v = 16'h0000;
    i_xps_smb_host.startCond();
    i_xps_smb_host.sendByte({devAddr, 1'b0}, ack);
    i_xps_smb_host.sendByte(idx, ack);
    i_xps_smb_host.startCond();
    i_xps_smb_host.sendByte({devAddr, 1'b1}, ack);
    check(20'(ack), 20'h1);
    for (int i = 0; i < n; i++)
    begin
      i_xps_smb_host.recvByte(i < n - 1, b);
      v[15-8*i-:8] = b;
    end
    i_xps_smb_host.stopCond();
  endtask

  // Expected enables follow from routing, control bits and the power pin.
  task automatic checkOuts();
    logic pu;
    logic [3:0] oe, ie;
    repeat (10) @(posedge clk);
    pu = powerDownPin | curCtrl[7];
    oe = pu ? curCtrl[3:0] : 4'h0;
    ie = {4{curCtrl[6]}};
    for (int n = 0; n < 4; n++)
    begin
      if (oe[n])
      begin
        ie[curRoute[2*n+:2]] = 1'b1;
      end
    end
    check({2'h0, outputSelect, powerUpMode, monitorEnable, outputPortEnable, inputPortEnable},
      {2'h0, curRoute, pu, curCtrl[6], oe, ie});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset_defaults();
    logic [15:0] v;
    checkOuts();
    regRead(IDX_SWITCH_ROUTING, 1, v);
    check(20'(v), 20'h0_0000);
    regRead(IDX_POWER_CONTROL, 1, v);
    check(20'(v), 20'h0_0F00);
    $display("test_reset_defaults done");
  endtask

  task automatic test_routing_codes();
    logic [7:0] routes [4] = '{8'hE4, 8'h1B, 8'h00, 8'hFF};
    logic [7:0] ctrls [4] = '{8'h8F, 8'h8A, 8'h85, 8'hC3};
    logic [15:0] v;
    for (int i = 0; i < 4; i++)
    begin
      curCtrl = ctrls[i];
      regWrite(IDX_POWER_CONTROL, {curCtrl, 8'h00}, 1, 1'b1);
      curRoute = routes[i];
      regWrite(IDX_SWITCH_ROUTING, {curRoute, 8'h00}, 1, 1'b1);
      checkOuts();
      regRead(IDX_SWITCH_ROUTING, 1, v);
      check(20'(v), {4'h0, curRoute, 8'h00});
    end
    $display("test_routing_codes done");
  endtask

  task automatic test_burst_readonly();
    logic [15:0] v;
    inputSignalValid <= 4'h9;
    curCtrl = 8'h77;
    regWrite(8'h02, {8'hAA, curCtrl}, 2, 1'b1);
    regWrite(IDX_SIGNAL_LOSS, 16'h5500, 1, 1'b1);
    regRead(IDX_POWER_CONTROL, 2, v);
    check(20'(v), {4'h0, curCtrl, 8'h09});
    regRead(8'h01, 1, v);
    check(20'(v), 20'h0_0000);
    checkOuts();
    $display("test_burst_readonly done");
  endtask

  task automatic test_pin_power();
    curCtrl = 8'h07;
    regWrite(IDX_POWER_CONTROL, {curCtrl, 8'h00}, 1, 1'b1);
    checkOuts();
    powerDownPin <= 1'b1;
    checkOuts();
    powerDownPin <= 1'b0;
    checkOuts();
    $display("test_pin_power done");
  endtask

  task automatic test_address_mode();
    devAddr = {ADDR_FIXED_BITS, ~busIdStrap};
    regWrite(IDX_SWITCH_ROUTING, 16'h1B00, 1, 1'b0);
    devAddr = {3'h4, busIdStrap};
    regWrite(IDX_SWITCH_ROUTING, 16'h1B00, 1, 1'b0);
    devAddr = {ADDR_FIXED_BITS, busIdStrap};
    busModeSelect <= 1'b0;
    regWrite(IDX_SWITCH_ROUTING, 16'h1B00, 1, 1'b0);
    checkOuts();
    busModeSelect <= 1'b1;
    busIdStrap <= 4'h9;
    devAddr = {ADDR_FIXED_BITS, 4'h9};
    curRoute = 8'h1B;
    regWrite(IDX_SWITCH_ROUTING, {curRoute, 8'h00}, 1, 1'b1);
    checkOuts();
    $display("test_address_mode done");
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    busModeSelect = 1'b1;
    busIdStrap = 4'h6;
    powerDownPin = 1'b0;
    inputSignalValid = 4'hF;
    devAddr = {ADDR_FIXED_BITS, 4'h6};
    curRoute = 8'h00;
    curCtrl = 8'h0F;
    numErrors = 0;
    checksDone = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    test_reset_defaults();
    test_routing_codes();
    test_burst_readonly();
    test_pin_power();
    test_address_mode();
    tally_and_finish();
  end
endmodule

`default_nettype wire
